/* File: src/pfg_defines.svh */
// Register map, field positions, reset values and widths of the block
`ifndef PFG_DEFINES_SVH
`define PFG_DEFINES_SVH

// ==========================================================
// Register addresses
`define PFG_ADDR_FILT 8'had
`define PFG_ADDR_EXIT 8'hb0

// ==========================================================
// Reset values and implemented-bit masks
`define PFG_FILT_RST 8'h08
`define PFG_EXIT_RST 8'h00
`define PFG_FILT_MASK 8'h2f
`define PFG_EXIT_MASK 8'h3f

// ==========================================================
// Field positions, measurement_filter_config
`define PFG_B_PAVG_ON 0
`define PFG_B_PAVG_DEPTH 1
`define PFG_B_PAVG_DEC 2
`define PFG_B_IR_OFF 3
`define PFG_B_ALS_ABORT 5

// ==========================================================
// Field positions, gesture_exit_config
`define PFG_IGN_MSB 5
`define PFG_IGN_LSB 2
`define PFG_PERS_MSB 1
`define PFG_PERS_LSB 0

// ==========================================================
// Data widths and channel count
`define PFG_REG_W 8
`define PFG_COLOR_W 16
`define PFG_PROX_W 8
`define PFG_GEST_W 8
`define PFG_NCHAN 4
`define PFG_WIN 4

`endif

/* File: src/pfg_pkg.sv */
// Shared types of the measurement post-processing block
`include "pfg_defines.svh"

package pfg_pkg;

    // ==========================================================
    // Gesture mode state
    typedef enum logic [0:0] {
        PFG_GS_OFF = 1'b0,
        PFG_GS_ON = 1'b1
    } pfg_gstate_t;

    typedef logic [`PFG_PROX_W-1:0] pfg_prox_t;
    typedef logic [`PFG_COLOR_W-1:0] pfg_color_t;
    typedef logic [`PFG_GEST_W-1:0] pfg_gest_t;

    // ==========================================================
    // Proximity averager state
    typedef struct packed {
        logic [`PFG_WIN-2:0][`PFG_PROX_W-1:0] win;
        logic [1:0] grp;
        logic [`PFG_PROX_W-1:0] res;
        logic res_v;
    } pfg_avg_st_t;

    // ==========================================================
    // Gesture exit state
    typedef struct packed {
        pfg_gstate_t gs;
        logic [3:0] cnt;
        logic exit;
    } pfg_exit_st_t;

    // ==========================================================
    // Top state
    typedef struct packed {
        logic [`PFG_REG_W-1:0] filt;
        logic [`PFG_REG_W-1:0] excfg;
        logic [`PFG_REG_W-1:0] rdata;
        logic abort;
        logic restart;
        logic [3:0][`PFG_COLOR_W-1:0] color;
        logic color_v;
    } pfg_top_st_t;

endpackage

/* File: src/pfg_prox_if.sv */
// Proximity sample and averaging-control group between top and averager
`timescale 1ns/1ps

interface pfg_prox_if;
    import pfg_pkg::*;
    logic sample_v;
    pfg_prox_t sample;
    logic on;
    logic depth;
    logic decimate;
    logic res_v;
    pfg_prox_t res;

    modport src (
        output sample_v, sample, on, depth, decimate,
        input res_v, res
    );
    modport avg (
        input sample_v, sample, on, depth, decimate,
        output res_v, res
    );
endinterface

/* File: src/pfg_prox_avg.sv */
// Proximity averager: raw, sliding-window or decimated average
`timescale 1ns/1ps
`include "pfg_defines.svh"

module pfg_prox_avg
    import pfg_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Sample group
    pfg_prox_if.avg px
);
    pfg_avg_st_t q, d;
    logic [`PFG_PROX_W+1:0] sum2, sum4;
    logic [1:0] last;

    always_comb begin
        d = q;
        d.res_v = 1'b0;
        sum2 = {2'b00, px.sample} + {2'b00, q.win[0]};
        sum4 = sum2 + {2'b00, q.win[1]} + {2'b00, q.win[2]};
        last = px.depth ? 2'h3 : 2'h1;
        if (px.sample_v) begin
            d.win = {q.win[`PFG_WIN-3:0], px.sample};
            if (!px.on) begin
                d.res = px.sample;
                d.res_v = 1'b1;
                d.grp = 2'h0;
            end else begin
                d.res = px.depth ? sum4[`PFG_PROX_W+1:2]
                                 : sum2[`PFG_PROX_W:1];
                if (!px.decimate) begin
                    d.res_v = 1'b1;
                    d.grp = 2'h0;
                end else if (q.grp == last) begin
                    d.res_v = 1'b1;
                    d.grp = 2'h0;
                end else begin
                    d.res = q.res;
                    d.grp = 2'(q.grp + 2'h1);
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign px.res_v = q.res_v;
    assign px.res = q.res;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    chk_raw_pass_through: assert property (
        px.sample_v && !px.on |=> px.res_v && px.res == $past(px.sample))
        else $error("raw proximity sample not reported");
    chk_decim_first_quiet: assert property (
        px.sample_v && px.on && px.decimate && q.grp == 2'h0 |=> !px.res_v)
        else $error("decimated result issued at group start");
endmodule

/* File: src/pfg_gest_exit.sv */
// Gesture mode tracking with masked, persistent exit decision
`timescale 1ns/1ps
`include "pfg_defines.svh"

module pfg_gest_exit
    import pfg_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Gesture measurements
    input wire logic i_enter,
    input wire logic i_valid,
    input wire logic [`PFG_NCHAN-1:0][`PFG_GEST_W-1:0] i_chan,
    input wire logic [`PFG_GEST_W-1:0] i_level,
    // Configuration
    input wire logic [`PFG_NCHAN-1:0] i_ignore,
    input wire logic [1:0] i_persist,
    // State
    output logic o_state,
    output logic o_exit
);
    pfg_exit_st_t q, d;
    logic [`PFG_NCHAN-1:0] below;
    logic all_below;
    logic [3:0] need;

    for (genvar c = 0; c < `PFG_NCHAN; c++) begin : g_chan
        assign below[c] = i_ignore[c] || (i_chan[c] < i_level);
    end
    assign all_below = &below;
    assign need = 4'h1 << i_persist;

    always_comb begin
        d = q;
        d.exit = 1'b0;
        case (q.gs)
            PFG_GS_OFF: begin
                d.cnt = 4'h0;
                if (i_enter) begin
                    d.gs = PFG_GS_ON;
                end
            end
            PFG_GS_ON: begin
                if (i_valid) begin
                    if (!all_below) begin
                        d.cnt = 4'h0;
                    end else if (4'(q.cnt + 4'h1) >= need) begin
                        d.gs = PFG_GS_OFF;
                        d.cnt = 4'h0;
                        d.exit = 1'b1;
                    end else begin
                        d.cnt = 4'(q.cnt + 4'h1);
                    end
                end
            end
            default: begin
                d.gs = PFG_GS_OFF;
                d.cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            q <= '{gs: PFG_GS_OFF, cnt: 4'h0, exit: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_state = (q.gs == PFG_GS_ON);
    assign o_exit = q.exit;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    chk_exit_after_below: assert property (
        $fell(o_state) |-> $past(i_valid && all_below))
        else $error("gesture exit without below-level sample");
    chk_exit_single_hit: assert property (
        o_state && i_valid && all_below && i_persist == 2'h0 |=> !o_state)
        else $error("persistence 0 did not exit on first hit");
    chk_exit_not_early: assert property (
        o_state && i_valid && i_persist == 2'h3 && q.cnt < 4'h7 |=> o_state)
        else $error("persistence 3 exited before eight hits");
endmodule

/* File: src/pfg_top.sv */
// Measurement post-processing: ALS abort, IR subtraction, prox avg, exit
// How it works
// - Abort bit set: gesture entry during ALS integration abandons it.
// - Abort bit set: start fresh ALS integration when gesture mode ends.
// - That restart skips the configured wait period.
// - IR-subtract-off bit resets to one; correction only while zero.
// - IR estimate is (R+G+B-C)/2; each colour result has it subtracted.
// - Averaging plus decimate: result and prox check once per group.
// - Averaging without decimate: sliding window, result every sample.
// - Depth bit: zero averages two samples, one averages four.
// - Averaging enable at bit zero; clear reports raw samples.
// - Exit ignore bits 5..2 mask east, west, south, north.
// - Leave gesture mode after enough consecutive below-level samples.
// - Persistence field 0..3 means 1, 2, 4, 8 occurrences.
`timescale 1ns/1ps
`include "pfg_defines.svh"

module pfg_top
    import pfg_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Register access
    input wire logic [7:0] i_reg_addr,
    input wire logic [`PFG_REG_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [`PFG_REG_W-1:0] o_reg_rdata,
    // ALS sequencing
    input wire logic i_als_busy,
    output logic o_als_abort,
    output logic o_als_restart,
    output logic o_als_skip_wait,
    // Colour data
    input wire logic i_color_v,
    input wire logic [`PFG_COLOR_W-1:0] i_red,
    input wire logic [`PFG_COLOR_W-1:0] i_green,
    input wire logic [`PFG_COLOR_W-1:0] i_blue,
    input wire logic [`PFG_COLOR_W-1:0] i_clear,
    output logic o_color_v,
    output logic [`PFG_COLOR_W-1:0] o_red,
    output logic [`PFG_COLOR_W-1:0] o_green,
    output logic [`PFG_COLOR_W-1:0] o_blue,
    output logic [`PFG_COLOR_W-1:0] o_clear,
    // Proximity data
    input wire logic i_prox_v,
    input wire logic [`PFG_PROX_W-1:0] i_prox_raw,
    output logic o_prox_check,
    output logic [`PFG_PROX_W-1:0] o_prox_result,
    // Gesture data
    input wire logic i_gest_enter,
    input wire logic i_gest_v,
    input wire logic [`PFG_GEST_W-1:0] i_north,
    input wire logic [`PFG_GEST_W-1:0] i_south,
    input wire logic [`PFG_GEST_W-1:0] i_west,
    input wire logic [`PFG_GEST_W-1:0] i_east,
    input wire logic [`PFG_GEST_W-1:0] i_gesture_exit_level,
    output logic o_gesture_state
);
    // ==========================================================
    // State and wiring
    pfg_top_st_t q, d;
    logic gest_exit;
    logic gest_entry;
    logic als_abort_on_gesture;
    logic ir_subtract_off;
    logic signed [`PFG_COLOR_W+2:0] ir_sum;
    logic signed [`PFG_COLOR_W+2:0] ir_est;
    logic [3:0][`PFG_COLOR_W-1:0] raw;
    logic [3:0][`PFG_COLOR_W-1:0] corr;

    pfg_prox_if px ();

    assign als_abort_on_gesture = q.filt[`PFG_B_ALS_ABORT];
    assign ir_subtract_off = q.filt[`PFG_B_IR_OFF];
    assign gest_entry = i_gest_enter && !o_gesture_state;

    // ==========================================================
    // IR estimate and saturating subtraction
    function automatic logic [`PFG_COLOR_W-1:0] sat_sub(
        input logic [`PFG_COLOR_W-1:0] v,
        input logic signed [`PFG_COLOR_W+2:0] ir
    );
        logic signed [`PFG_COLOR_W+3:0] r;
        r = $signed({4'h0, v}) - {ir[`PFG_COLOR_W+2], ir};
        if (r < 0) begin
            sat_sub = '0;
        end else if (r[`PFG_COLOR_W+3:`PFG_COLOR_W] != 4'h0) begin
            sat_sub = '1;
        end else begin
            sat_sub = r[`PFG_COLOR_W-1:0];
        end
    endfunction

    assign raw = {i_clear, i_blue, i_green, i_red};
    assign ir_sum = $signed({3'h0, i_red}) + $signed({3'h0, i_green})
                  + $signed({3'h0, i_blue}) - $signed({3'h0, i_clear});
    assign ir_est = ir_sum >>> 1;

    for (genvar k = 0; k < 4; k++) begin : g_corr
        assign corr[k] = sat_sub(raw[k], ir_est);
    end

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.abort = 1'b0;
        d.restart = 1'b0;
        d.color_v = 1'b0;
        if (i_reg_wr && i_reg_addr == `PFG_ADDR_FILT) begin
            d.filt = i_reg_wdata & `PFG_FILT_MASK;
        end
        if (i_reg_wr && i_reg_addr == `PFG_ADDR_EXIT) begin
            d.excfg = i_reg_wdata & `PFG_EXIT_MASK;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                `PFG_ADDR_FILT: d.rdata = q.filt & `PFG_FILT_MASK;
                `PFG_ADDR_EXIT: d.rdata = q.excfg & `PFG_EXIT_MASK;
                default: d.rdata = '0;
            endcase
        end
        d.abort = als_abort_on_gesture && gest_entry && i_als_busy;
        // fresh integration when gesture mode ends
        d.restart = als_abort_on_gesture && gest_exit;
        if (i_color_v) begin
            d.color_v = 1'b1;
            // correction only while the bit is zero
            d.color = ir_subtract_off ? raw : corr;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            q <= '0;
            q.filt <= `PFG_FILT_RST;
            q.excfg <= `PFG_EXIT_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign o_reg_rdata = q.rdata;
    assign o_als_abort = q.abort;
    assign o_als_restart = q.restart;
    assign o_als_skip_wait = q.restart;
    assign o_color_v = q.color_v;
    assign o_red = q.color[0];
    assign o_green = q.color[1];
    assign o_blue = q.color[2];
    assign o_clear = q.color[3];

    // ==========================================================
    // Proximity averaging
    assign px.sample_v = i_prox_v;
    assign px.sample = i_prox_raw;
    assign px.on = q.filt[`PFG_B_PAVG_ON];
    assign px.depth = q.filt[`PFG_B_PAVG_DEPTH];
    assign px.decimate = q.filt[`PFG_B_PAVG_DEC];
    assign o_prox_check = px.res_v;
    assign o_prox_result = px.res;

    pfg_prox_avg u_avg (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .px(px)
    );

    // ==========================================================
    // Gesture exit
    pfg_gest_exit u_exit (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_enter(i_gest_enter),
        .i_valid(i_gest_v),
        .i_chan({i_east, i_west, i_south, i_north}),
        .i_level(i_gesture_exit_level),
        .i_ignore(q.excfg[`PFG_IGN_MSB:`PFG_IGN_LSB]),
        .i_persist(q.excfg[`PFG_PERS_MSB:`PFG_PERS_LSB]),
        .o_state(o_gesture_state),
        .o_exit(gest_exit)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    sequence s_entry_busy;
        i_gest_enter && !o_gesture_state && i_als_busy;
    endsequence

    sequence s_gest_end;
        o_gesture_state ##1 !o_gesture_state;
    endsequence

    chk_abort_on_entry: assert property (
        s_entry_busy and als_abort_on_gesture |=> o_als_abort)
        else $error("ALS not aborted on gesture entry");
    chk_abort_needs_bit: assert property (
        o_als_abort |-> $past(als_abort_on_gesture) && $past(i_als_busy))
        else $error("ALS abort without enable or integration");
    chk_restart_on_exit: assert property (
        s_gest_end ##0 als_abort_on_gesture |=> o_als_restart)
        else $error("ALS not restarted after gesture end");
    chk_restart_skip: assert property (
        $rose(o_als_restart) |-> o_als_skip_wait ##1 !o_als_skip_wait)
        else $error("restart did not skip wait for one cycle");
    chk_ir_reset_one: assert property (
        $past(i_srst) |-> ir_subtract_off)
        else $error("IR correction enabled after reset");
    chk_ir_bypass: assert property (
        i_color_v && ir_subtract_off |=> o_color_v && o_red == $past(i_red)
            && o_clear == $past(i_clear))
        else $error("uncorrected colour altered");
    chk_ir_balance: assert property (
        i_color_v && !ir_subtract_off && i_red >= i_green
            && corr[0] != '0 && corr[1] != '0 && corr[0] != '1
        |=> o_red - o_green == $past(i_red - i_green))
        else $error("IR estimate not subtracted equally");
    chk_prox_every: assert property (
        i_prox_v && px.on && !px.decimate |=> o_prox_check)
        else $error("sliding window missed a sample");
    chk_prox_idle: assert property (
        !i_prox_v |=> !o_prox_check)
        else $error("proximity check without sample");
    chk_rsvd_zero: assert property (
        i_reg_rd && i_reg_addr == `PFG_ADDR_FILT
        |=> (o_reg_rdata & ~`PFG_FILT_MASK) == '0)
        else $error("reserved bits read non-zero");
    chk_mask_all: assert property (
        o_gesture_state && i_gest_v && q.excfg[`PFG_IGN_MSB:`PFG_IGN_LSB]
            == 4'hf && q.excfg[`PFG_PERS_MSB:`PFG_PERS_LSB] == 2'h0
        |=> !o_gesture_state)
        else $error("fully masked exit not taken");
    chk_abort_idle: assert property (
        !als_abort_on_gesture |=> !o_als_abort)
        else $error("ALS aborted with abort bit clear");
    chk_restart_needs_bit: assert property (
        !als_abort_on_gesture |=> !o_als_restart)
        else $error("ALS restarted with abort bit clear");
    chk_color_one_cycle: assert property (
        i_color_v |=> o_color_v)
        else $error("colour result not issued");
    chk_color_pulse: assert property (
        !i_color_v |=> !o_color_v)
        else $error("colour valid without sample");
    chk_rsvd_exit_zero: assert property (
        i_reg_rd && i_reg_addr == `PFG_ADDR_EXIT
        |=> (o_reg_rdata & ~`PFG_EXIT_MASK) == '0)
        else $error("reserved exit bits read non-zero");
endmodule

/* File: tb/pfg_host_model.sv */
// Host-side register access model for the post-processing block
`timescale 1ns/1ps

module pfg_host_model (
    // Clock and read data
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    // Register strobes
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // ==========================================================
    // Register cycles
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_ref_clk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_ref_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_ref_clk);
        o_rd = 1'b0;
        d = i_rdata;
    endtask
endmodule

/* File: tb/tb_prox_avg_on_gesture_exit.sv */
// Self-checking bench of the measurement post-processing block
`timescale 1ns/1ps
`include "pfg_defines.svh"

module tb_prox_avg_on_gesture_exit;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, o_reg_rdata, rd;
    logic reg_wr, reg_rd, o_als_abort, o_als_restart, o_als_skip_wait;
    logic i_als_busy = 1'b0;
    logic i_color_v = 1'b0;
    logic [63:0] col_in = 64'h0;
    logic o_color_v;
    logic [15:0] o_red, o_green, o_blue, o_clear;
    logic i_prox_v = 1'b0;
    logic [7:0] i_prox_raw = 8'h00;
    logic o_prox_check;
    logic [7:0] o_prox_result;
    logic i_gest_enter = 1'b0;
    logic i_gest_v = 1'b0;
    logic [31:0] nswe = 32'h0;
    logic [7:0] i_gesture_exit_level = 8'h40;
    logic o_gesture_state;
    int bad_count = 0;
    int check_count = 0;
    localparam logic [31:0] low_lvl = 32'h10101010;

    // ==========================================================
    // Rows: cfg, r g b c in, r g b c out
    localparam logic [135:0] col_rows [4] = '{
        {8'h08, 64'h0064_0032_001e_0078, 64'h0064_0032_001e_0078},
        {8'h00, 64'h0064_0032_001e_0078, 64'h0046_0014_0000_005a},
        {8'h00, 64'h0000_0000_0000_0003, 64'h0002_0002_0002_0005},
        {8'h00, 64'hfff0_0000_0000_ffff, 64'hfff8_0008_0008_ffff}};
    // Rows: cfg, raw sample, check pulse, result
    localparam logic [27:0] prox_rows [17] = '{
        {8'h08, 8'h37, 4'h1, 8'h37}, {8'h09, 8'h14, 4'h1, 8'h0a},
        {8'h09, 8'h0a, 4'h1, 8'h0f}, {8'h09, 8'hff, 4'h1, 8'h84},
        {8'h0b, 8'h28, 4'h1, 8'h0a}, {8'h0b, 8'h28, 4'h1, 8'h14},
        {8'h0b, 8'h28, 4'h1, 8'h1e}, {8'h0b, 8'h28, 4'h1, 8'h28},
        {8'h0b, 8'h00, 4'h1, 8'h1e}, {8'h0d, 8'h14, 4'h0, 8'h00},
        {8'h0d, 8'h0a, 4'h1, 8'h0f}, {8'h0d, 8'h1e, 4'h0, 8'h0f},
        {8'h0d, 8'h32, 4'h1, 8'h28}, {8'h0f, 8'h04, 4'h0, 8'h00},
        {8'h0f, 8'h08, 4'h0, 8'h00}, {8'h0f, 8'h0c, 4'h0, 8'h00},
        {8'h0f, 8'h10, 4'h1, 8'h0a}};

    always #2 i_ref_clk = ~i_ref_clk;

    pfg_host_model host (
        .i_ref_clk(i_ref_clk), .i_rdata(o_reg_rdata), .o_addr(reg_addr),
        .o_wdata(reg_wdata), .o_wr(reg_wr), .o_rd(reg_rd));

    pfg_top DUT (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_als_busy(i_als_busy),
        .o_als_abort(o_als_abort), .o_als_restart(o_als_restart),
        .o_als_skip_wait(o_als_skip_wait), .i_color_v(i_color_v),
        .i_red(col_in[63:48]), .i_green(col_in[47:32]),
        .i_blue(col_in[31:16]), .i_clear(col_in[15:0]),
        .o_color_v(o_color_v), .o_red(o_red), .o_green(o_green),
        .o_blue(o_blue), .o_clear(o_clear), .i_prox_v(i_prox_v),
        .i_prox_raw(i_prox_raw), .o_prox_check(o_prox_check),
        .o_prox_result(o_prox_result), .i_gest_enter(i_gest_enter),
        .i_gest_v(i_gest_v), .i_north(nswe[31:24]), .i_south(nswe[23:16]),
        .i_west(nswe[15:8]), .i_east(nswe[7:0]),
        .i_gesture_exit_level(i_gesture_exit_level),
        .o_gesture_state(o_gesture_state));

    // ==========================================================
    // Helpers
    task automatic check_val(input string nm, input logic [15:0] ex,
                             input logic [15:0] got);
        check_count++;
        if (got !== ex) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge i_ref_clk);
        i_srst = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        i_srst = 1'b0;
    endtask

    task automatic enter_mode(input logic busy);
        @(negedge i_ref_clk);
        i_gest_enter = 1'b1;
        i_als_busy = busy;
        @(negedge i_ref_clk);
        i_gest_enter = 1'b0;
        i_als_busy = 1'b0;
    endtask

    task automatic gsamp(input logic [31:0] v);
        @(negedge i_ref_clk);
        nswe = v;
        i_gest_v = 1'b1;
        @(negedge i_ref_clk);
        i_gest_v = 1'b0;
    endtask

    initial begin
        #200000;
        bad_count++;
        complete_run();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] cur;
        cur = 8'hff;
        repeat (10) @(negedge i_ref_clk);
        i_srst = 1'b0;
        host.read_reg(`PFG_ADDR_FILT, rd);
        check_val("filt_rst", 16'h0008, {8'h00, rd}); // default
        host.read_reg(`PFG_ADDR_EXIT, rd);
        check_val("exit_rst", 16'h0000, {8'h00, rd}); // default
        host.write_reg(`PFG_ADDR_FILT, 8'hff);
        host.write_reg(`PFG_ADDR_EXIT, 8'hff);
        host.write_reg(8'hae, 8'hff);
        host.read_reg(`PFG_ADDR_FILT, rd);
        check_val("filt_rd", 16'h002f, {8'h00, rd}); // reserved
        host.read_reg(`PFG_ADDR_EXIT, rd);
        check_val("exit_rd", 16'h003f, {8'h00, rd}); // reserved
        host.read_reg(8'hae, rd);
        check_val("unmapped", 16'h0000, {8'h00, rd}); // empty
        do_reset();
        host.read_reg(`PFG_ADDR_FILT, rd);
        check_val("filt_rst2", 16'h0008, {8'h00, rd}); // again
        for (int i = 0; i < 4; i++) begin
            if (i > 0) begin
                host.write_reg(`PFG_ADDR_FILT, col_rows[i][135:128]);
            end
            @(negedge i_ref_clk);
            col_in = col_rows[i][127:64];
            i_color_v = 1'b1;
            @(negedge i_ref_clk);
            i_color_v = 1'b0;
            check_val("color_v", 16'h0001, {15'h0, o_color_v}); // out
            check_val("red", col_rows[i][63:48], o_red); // red
            check_val("green", col_rows[i][47:32], o_green); // green
            check_val("blue", col_rows[i][31:16], o_blue); // blue
            check_val("clear", col_rows[i][15:0], o_clear); // clear
        end
        for (int i = 0; i < 17; i++) begin
            if (prox_rows[i][27:20] !== cur) begin
                cur = prox_rows[i][27:20];
                do_reset();
                host.write_reg(`PFG_ADDR_FILT, cur);
            end
            @(negedge i_ref_clk);
            i_prox_raw = prox_rows[i][19:12];
            i_prox_v = 1'b1;
            @(negedge i_ref_clk);
            i_prox_v = 1'b0;
            i_prox_raw = ~i_prox_raw;
            check_val("prox_chk", {15'h0, prox_rows[i][8]},
                      {15'h0, o_prox_check}); // pulse
            check_val("prox_res", {8'h00, prox_rows[i][7:0]},
                      {8'h00, o_prox_result}); // value
        end
        host.write_reg(`PFG_ADDR_FILT, 8'h28);
        for (int p = 0; p < 4; p++) begin
            host.write_reg(`PFG_ADDR_EXIT, {6'h00, p[1:0]});
            enter_mode(1'b1);
            check_val("abort", 16'h0001, {15'h0, o_als_abort}); // pulse
            repeat ((1 << p) - 1) gsamp(low_lvl);
            gsamp(low_lvl | 32'h00004000);
            repeat ((1 << p) - 1) gsamp(low_lvl);
            check_val("gs_held", 16'h0001, {15'h0, o_gesture_state});
            gsamp(low_lvl);
            check_val("gs_left", 16'h0000, {15'h0, o_gesture_state});
            check_val("rst_early", 16'h0000, {15'h0, o_als_restart});
            @(negedge i_ref_clk);
            check_val("restart", 16'h0001, {15'h0, o_als_restart});
            check_val("skip", 16'h0001, {15'h0, o_als_skip_wait}); // skip
        end
        host.write_reg(`PFG_ADDR_FILT, 8'h08);
        for (int k = 0; k < 4; k++) begin
            host.write_reg(`PFG_ADDR_EXIT, 8'h04 << k);
            enter_mode(1'b1);
            check_val("abort_off", 16'h0000, {15'h0, o_als_abort}); // off
            gsamp(low_lvl | (32'h40000000 >> (8 * ((k + 1) % 4))));
            check_val("gs_kept", 16'h0001, {15'h0, o_gesture_state});
            gsamp(low_lvl | (32'h40000000 >> (8 * k)));
            check_val("gs_mask", 16'h0000, {15'h0, o_gesture_state});
            @(negedge i_ref_clk);
            check_val("rst_off", 16'h0000, {15'h0, o_als_restart}); // off
        end
        // All channels masked exits at once
        host.write_reg(`PFG_ADDR_EXIT, 8'h3c);
        enter_mode(1'b0);
        gsamp(32'hffffffff);
        check_val("gs_all", 16'h0000, {15'h0, o_gesture_state}); // all
        complete_run();
    end
endmodule
